/* hw/sstf_top.sv */
// scan sequencer with external frame-start synchronisation
`timescale 1ns/10ps
`default_nettype none
module sstf_top (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic lowOscClk,
   input wire logic extFrameStart,
   input wire sstf_pkg::sstf_ctrl_type ctrl,
   output sstf_pkg::sstf_stat_type stat
);
   import sstf_pkg::*;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic [1:0] rstSync_r;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   wire logic rstn = rstSync_r[1];

   typedef struct packed {
      sstf_state_type st;
      logic [2:0] oscSync;
      logic [2:0] trgSync;
      logic [2:0] trgHigh;
      logic [2:0] armGap;
      logic trgSeen;
      logic [15:0] cnt;
      logic [1:0] widget;
      sstf_stat_type out;
   } sstf_regs_type;

   sstf_regs_type s_r, s_nxt;

   function automatic logic [1:0] nextWidget(input logic [1:0] cur, input logic [SSTF_WIDGETS-1:0] m);
      logic [1:0] r;
      r = cur;
      for (int i = SSTF_WIDGETS - 1; i >= 1; i--) begin
         if (m[(cur + i[1:0]) % SSTF_WIDGETS] == 1'b1) begin
            r = 2'((cur + i[1:0]) % SSTF_WIDGETS);
         end
      end
      return r;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic oscTick, trgLvl, lastWidget;
   always_comb begin
      s_nxt = s_r;
      // bits 0 of each sync chain feed only bit 1
      s_nxt.oscSync = {s_r.oscSync[1:0], lowOscClk};
      s_nxt.trgSync = {s_r.trgSync[1:0], extFrameStart};
      oscTick = s_r.oscSync[1] & ~s_r.oscSync[2];
      trgLvl = s_r.trgSync[1];
      lastWidget = !ctrl.multiWidget || nextWidget(s_r.widget, ctrl.widgetMask) <= s_r.widget;
      s_nxt.out.wakeIrq = 1'b0;
      s_nxt.out.frameDone = 1'b0;
      // pulse width measured in low-speed cycles filters glitches
      if (!trgLvl) begin
         s_nxt.trgHigh = 3'h0;
         s_nxt.trgSeen = 1'b0;
      end else if (oscTick && s_r.trgHigh != 3'h7) begin
         s_nxt.trgHigh = s_r.trgHigh + 3'h1;
      end
      if (oscTick && s_r.armGap != 3'h7) begin
         s_nxt.armGap = s_r.armGap + 3'h1;
      end
      if (ctrl.deepSleep) begin
         s_nxt.st = ST_IDLE;
         s_nxt.out.busy = 1'b0;
         s_nxt.out.muxConnect = '0;
      end else begin
         unique case (s_r.st)
            ST_IDLE: begin
               if (ctrl.armReq) begin
                  s_nxt.widget = 2'h0;
                  if (ctrl.extFrameEn) begin
                     s_nxt.st = ST_ARMED;
                     s_nxt.armGap = 3'h0;
                     // a pulse already high when armed is not a new pulse
                     s_nxt.trgSeen = trgLvl;
                  end else begin
                     s_nxt.st = ST_SCAN;
                     s_nxt.cnt = ctrl.scanLen;
                  end
               end
            end
            ST_ARMED: begin
               // start once pulse is qualified and arm gap met
               // trigger must still be high, so a pulse that has just ended starts nothing
               if (trgLvl && !s_r.trgSeen && s_r.trgHigh >= SSTF_LOSC_MIN_PULSE
                   && s_r.armGap >= SSTF_LOSC_ARM_GAP) begin
                  s_nxt.st = ST_SCAN;
                  s_nxt.trgSeen = 1'b1;
                  s_nxt.cnt = ctrl.scanLen;
               end
            end
            ST_SCAN: begin
               // runs to completion unless deep sleep parks it
               if (s_r.cnt == 16'h0000) begin
                  s_nxt.out.wakeIrq = 1'b1;
                  if (lastWidget) begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.out.frameDone = 1'b1;
                  end else begin
                     s_nxt.widget = nextWidget(s_r.widget, ctrl.widgetMask);
                     s_nxt.cnt = ctrl.scanLen;
                  end
               end else begin
                  s_nxt.cnt = s_r.cnt - 16'h0001;
               end
            end
         endcase
         s_nxt.out.busy = (s_nxt.st == ST_SCAN);
         // a wake pulse reports the widget that has just finished, not the next one
         s_nxt.out.widgetIdx = s_nxt.out.wakeIrq ? s_r.widget : s_nxt.widget;
         if (s_nxt.st != ST_SCAN) begin
            s_nxt.out.muxConnect = '0;
         end else if (ctrl.ganged) begin
            s_nxt.out.muxConnect = ctrl.sensorSel;
         end else begin
            s_nxt.out.muxConnect = ctrl.sensorSel & (ctrl.sensorSel ^ (ctrl.sensorSel - 1'b1)) & ctrl.sensorSel;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign stat = s_r.out;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // deep sleep: engine parked, nothing connected, nothing wakes
   a_sleep_idle: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl.deepSleep |=> !stat.busy)
      else $error("scan active in deep sleep");
   a_sleep_disarm: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl.deepSleep |=> s_r.st == ST_IDLE)
      else $error("engine not parked in deep sleep");
   a_deep_quiet: assert property (@(posedge mclk) disable iff (!rstn)
      ctrl.deepSleep |=> (!stat.wakeIrq && stat.muxConnect == '0))
      else $error("activity in deep sleep");

   // ----------------------------------------
   // scan run and wake
   // ----------------------------------------
   a_direct_start: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_IDLE && ctrl.armReq && !ctrl.extFrameEn && !ctrl.deepSleep) |=> s_r.st == ST_SCAN)
      else $error("direct start not taken");
   a_scan_runs: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_SCAN && s_r.cnt != 16'h0000 && !ctrl.deepSleep) |=> s_r.st == ST_SCAN)
      else $error("scan stopped before its end");
   a_scan_busy: assert property (@(posedge mclk) disable iff (!rstn)
      s_r.st == ST_SCAN |-> stat.busy)
      else $error("scan running without busy");
   a_done_wakes: assert property (@(posedge mclk) disable iff (!rstn)
      stat.frameDone |-> stat.wakeIrq)
      else $error("frame done without wake");
   a_widget_wake: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_SCAN && s_r.cnt == 16'h0000 && !ctrl.deepSleep) |=> stat.wakeIrq)
      else $error("widget end without wake");

   // ----------------------------------------
   // analog mux connection
   // ----------------------------------------
   a_idle_mux: assert property (@(posedge mclk) disable iff (!rstn)
      !stat.busy |-> stat.muxConnect == '0)
      else $error("mux connected while idle");
   a_gang_all: assert property (@(posedge mclk) disable iff (!rstn)
      (stat.busy && $stable(ctrl) && ctrl.ganged && !ctrl.deepSleep) |-> stat.muxConnect == ctrl.sensorSel)
      else $error("ganged sensors not all connected");
   a_single_mux: assert property (@(posedge mclk) disable iff (!rstn)
      (stat.busy && $stable(ctrl) && !ctrl.ganged && !ctrl.deepSleep) |-> $onehot0(stat.muxConnect))
      else $error("several sensors connected outside ganged mode");

   // ----------------------------------------
   // frame trigger qualification
   // ----------------------------------------
   // the trigger is qualified before the start, so these after a_armed_entry look at the armed state
   a_armed_entry: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_IDLE && ctrl.armReq && ctrl.extFrameEn && !ctrl.deepSleep) |=> s_r.st == ST_ARMED)
      else $error("arm request not taken");
   a_armed_quiet: assert property (@(posedge mclk) disable iff (!rstn)
      s_r.st == ST_ARMED |-> !stat.busy)
      else $error("busy while waiting for trigger");
   a_arm_hold: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_ARMED && !trgLvl && !ctrl.deepSleep) |=> s_r.st != ST_SCAN)
      else $error("scan started without trigger");
   a_stale_trig: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_ARMED && s_r.trgSeen) |=> s_r.st != ST_SCAN)
      else $error("pulse present at arming started a scan");
   a_trig_width: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_ARMED && s_r.trgHigh < SSTF_LOSC_MIN_PULSE) |=> s_r.st != ST_SCAN)
      else $error("short pulse started a scan");
   a_trig_gap: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_ARMED && s_r.armGap < SSTF_LOSC_ARM_GAP) |=> s_r.st != ST_SCAN)
      else $error("scan started too soon after arming");

   // ----------------------------------------
   // one frame per arming
   // ----------------------------------------
   a_no_retrig: assert property (@(posedge mclk) disable iff (!rstn)
      (s_r.st == ST_IDLE && !ctrl.armReq) |=> s_r.st == ST_IDLE)
      else $error("scan without arming");
   a_frame_idle: assert property (@(posedge mclk) disable iff (!rstn)
      stat.frameDone |-> s_r.st == ST_IDLE)
      else $error("engine still active after frame end");
endmodule
`default_nettype wire

/* hw/sstf_pkg.sv */
// package for the scan sequencing and frame trigger block
package sstf_pkg;
   localparam int SSTF_SENSORS = 8;
   localparam int SSTF_WIDGETS = 4;
   localparam logic [2:0] SSTF_LOSC_MIN_PULSE = 3'h2;
   localparam logic [2:0] SSTF_LOSC_ARM_GAP = 3'h2;
   localparam logic [15:0] SSTF_SCAN_LEN_RST = 16'h0010;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_SCAN
   } sstf_state_type;

   typedef struct packed {
      logic armReq;
      logic extFrameEn;
      logic multiWidget;
      logic ganged;
      logic deepSleep;
      logic [SSTF_WIDGETS-1:0] widgetMask;
      logic [SSTF_SENSORS-1:0] sensorSel;
      logic [15:0] scanLen;
   } sstf_ctrl_type;

   typedef struct packed {
      logic busy;
      logic wakeIrq;
      logic frameDone;
      logic [SSTF_SENSORS-1:0] muxConnect;
      logic [1:0] widgetIdx;
   } sstf_stat_type;
endpackage

/* bench/sstf_sync_src.sv */
// frame sync source model
`timescale 1ns/10ps
`default_nettype none
module sstf_sync_src (
   input wire logic lowOscClk,
   output var logic extFrameStart
);
   // driven line, parks low between pulses
   initial extFrameStart = 1'b0;
   task automatic pulse(input int width);
      @(posedge lowOscClk);
      extFrameStart <= 1'b1;
      repeat (width) @(posedge lowOscClk);
      extFrameStart <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* bench/sense_scan_frame_trigger_test.sv */
// self-checking bench for the scan sequencer
`timescale 1ns/10ps
`default_nettype none
module sense_scan_frame_trigger_test;
   import sstf_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, lowOscClk = 1'b0;
   wire extFrameStart;
   sstf_ctrl_type ctrl = '0;
   sstf_stat_type stat;
   logic [2:0] expQ[$];
   int n_errors = 0, n_tests = 0, seed = 32'h9A94;
   always #2.5 mclk = ~mclk;
   // slow clock kept fast so the run stays short
   always #25 lowOscClk = ~lowOscClk;
   sstf_top sstf_top_inst (.mclk(mclk), .resetn(resetn), .lowOscClk(lowOscClk),
      .extFrameStart(extFrameStart), .ctrl(ctrl), .stat(stat));
   sstf_sync_src sstf_sync_src_inst (.lowOscClk(lowOscClk), .extFrameStart(extFrameStart));
   // ----
   // helpers
   // ----
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // fresh scan length and sensor choice on every arming
   task automatic arm();
      @(posedge mclk);
      ctrl.armReq <= 1'b1;
      ctrl.scanLen <= 16'h0008 + 16'($random(seed) & 7);
      ctrl.sensorSel <= 8'($random(seed)) | 8'h01;
      @(posedge mclk) ctrl.armReq <= 1'b0;
   endtask
   // widget 0 first, then each other masked widget upwards; last one ends the frame
   task automatic expectFrame(input logic multi, input logic [3:0] mask);
      logic [1:0] last;
      last = 2'h0;
      if (multi) begin
         for (int j = 1; j < 4; j++) begin
            if (mask[j]) begin
               expQ.push_back({1'b0, last});
               last = 2'(j);
            end
         end
      end
      expQ.push_back({1'b1, last});
   endtask
   task automatic waitQ();
      int i;
      for (i = 0; i < 4000 && expQ.size() != 0; i++) @(posedge mclk);
      if (expQ.size() != 0) begin
         n_errors++;
         $display("unexpected timeout expected done seen none");
         final_report();
      end
      repeat (8) @(posedge mclk);
   endtask
   // every wake pulse must match the oldest note
   always @(posedge mclk) begin
      if (stat.wakeIrq === 1'b1) begin
         if (expQ.size() == 0) check("wakeIrq", 8'h1, 8'h0);
         else check("widget", 8'({stat.frameDone, stat.widgetIdx}), 8'(expQ.pop_front()));
      end
   end
   // ----
   // scenarios
   // ----
   initial begin
      logic [3:0] mask;
      ctrl.scanLen <= 16'h0008 + 16'($random(seed) & 7);
      ctrl.sensorSel <= 8'($random(seed)) | 8'h01;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      ctrl.ganged <= 1'b1;
      expectFrame(1'b0, 4'h0);
      arm();
      repeat (3) @(posedge mclk);
      check("busy", 8'(stat.busy), 8'h1);
      check("mux", stat.muxConnect, ctrl.sensorSel);
      waitQ();
      ctrl.ganged <= 1'b0;
      ctrl.multiWidget <= 1'b1;
      mask = 4'($random(seed)) | 4'hA;
      ctrl.widgetMask <= mask;
      expectFrame(1'b1, mask);
      arm();
      waitQ();
      ctrl.multiWidget <= 1'b0;
      ctrl.deepSleep <= 1'b1;
      arm();
      repeat (40) @(posedge mclk);
      check("sleepBusy", 8'(stat.busy), 8'h0);
      ctrl.deepSleep <= 1'b0;
      ctrl.extFrameEn <= 1'b1;
      // pulse before arming must start nothing
      sstf_sync_src_inst.pulse(3);
      repeat (20) @(posedge mclk);
      arm();
      expectFrame(1'b0, 4'h0);
      repeat (3) @(posedge lowOscClk);
      sstf_sync_src_inst.pulse(3);
      waitQ();
      sstf_sync_src_inst.pulse(3);
      repeat (40) @(posedge mclk);
      check("rearmBusy", 8'(stat.busy), 8'h0);
      final_report();
   end
endmodule
`default_nettype wire
